// ### src/fsq_ctrl.sv
// fsq_ctrl: host sequencer for buffered program and extra-block lock
`timescale 1ns/1ps
`default_nettype none
// Function
// - lock customer section by programming protection bit to 0.
// - after locking, host issues exit-extra-block command.
// - all write-to-buffer data addresses lie inside one buffer page.
// - host writes count n, where n+1 words are loaded; a load cut short at the page edge still writes op_count as n.
// - after error flag, host re-reads the polling bit.
// - write-to-buffer: reset on failure, abort-and-reset on abort.
// - enhanced program starts at offset 00 with consecutive addresses.
// - enhanced: reset on failure, its abort-and-reset on abort.
module fsq_ctrl
  import fsq_pkg::*;
#(
  parameter int PAGE_W = 5,
  parameter int MAX_WORDS = 256
) (
  input  wire logic           ref_clk,
  input  wire logic           rst_b,
  input  wire logic           op_valid,
  input  wire fsq_pkg::fsq_op_t op,
  input  wire logic [22:0]    op_addr,
  input  wire logic [8:0]     op_count,
  input  wire logic [15:0]    wr_data,
  output logic                wr_take,
  output logic                op_busy,
  output logic                op_done,
  output fsq_pkg::fsq_res_t   op_res,
  output logic [15:0]         op_rdata,
  output logic                ce_b,
  output logic                we_b,
  output logic                oe_b,
  output logic [22:0]         adr,
  output logic [15:0]         dq_o,
  output logic                dq_oe_b,
  input  wire logic [15:0]    dq_i
);
  import fsq_pkg::*;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_s1_q, rst_q_b;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_q_b  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q_b  <= rst_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_CMD = 4'b0001, S_CNT = 4'b0011, S_DATA = 4'b0010,
    S_GO   = 4'b0110, S_POLL = 4'b0111, S_REPOLL = 4'b0101, S_RCV = 4'b0100,
    S_LCHK = 4'b1100, S_LPROG = 4'b1101, S_EXIT = 4'b1111, S_FIN = 4'b1110
  } fsq_st_t;

  function automatic logic same_page(input logic [22:0] a, input logic [22:0] b);
    same_page = (a[22:PAGE_W] == b[22:PAGE_W]);
  endfunction

  fsq_st_t     st_q, st_d;
  fsq_op_t     op_q, op_d;
  fsq_res_t    res_q, res_d;
  logic [22:0] base_q, base_d, cur_q, cur_d;
  logic [8:0]  left_q, left_d, n_q, n_d;
  logic        bs, bdone;
  fsq_bus_t    bk;
  logic [22:0] ba;
  logic [15:0] bw, brd;
  logic        take_d, busy_d, done_d;
  logic [15:0] rd_d;

  always_comb begin
    st_d = st_q; op_d = op_q; res_d = res_q;
    base_d = base_q; cur_d = cur_q; left_d = left_q; n_d = n_q;
    bs = 1'b0; bk = FSQ_BUS_WR; ba = cur_q; bw = 16'h0000;
    take_d = 1'b0; done_d = 1'b0; rd_d = op_rdata;
    case (st_q)
      S_IDLE: begin
        if (op_valid) begin
          op_d = op; res_d = FSQ_RES_OK;
          // enhanced program always starts at offset 00
          base_d = (op == FSQ_OP_EBP) ? {op_addr[22:8], 8'h00} : op_addr;
          cur_d  = base_d;
          n_d    = (op == FSQ_OP_EBP) ? 9'(MAX_WORDS - 1) : op_count;
          left_d = n_d;
          case (op)
            FSQ_OP_READ: st_d = S_RCV;
            FSQ_OP_LOCK: st_d = S_LCHK;
            default:     st_d = S_CMD;
          endcase
        end
      end
      S_CMD: begin
        bs = 1'b1; ba = base_q;
        bw = (op_q == FSQ_OP_EBP) ? CMD_EBP : CMD_WBUF;
        if (bdone) st_d = (op_q == FSQ_OP_EBP) ? S_DATA : S_CNT;
      end
      S_CNT: begin
        bs = 1'b1; ba = base_q; bw = {7'h00, n_q};
        if (bdone) st_d = S_DATA;
      end
      S_DATA: begin
        bs = 1'b1; bw = wr_data;
        if (bdone) begin
          take_d = 1'b1;
          cur_d  = cur_q + 23'h1;
          if (left_q == 9'h0) st_d = S_GO;
          else left_d = left_q - 9'h1;
          // in write-to-buffer, a word that would leave the page ends the load early
          if (op_q == FSQ_OP_WBUF && !same_page(cur_q + 23'h1, base_q)) st_d = S_GO;
        end
      end
      S_GO: begin
        bs = 1'b1; ba = base_q;
        bw = (op_q == FSQ_OP_EBP) ? CMD_EBP_GO : CMD_WBUF_GO;
        if (bdone) st_d = S_POLL;
      end
      S_POLL, S_REPOLL: begin
        bs = 1'b1; bk = FSQ_BUS_RD; ba = cur_q - 23'h1;
        if (bdone) begin
          if (brd[LOCK_HI_BIT] == wr_data[LOCK_HI_BIT] && st_q == S_REPOLL) st_d = S_FIN;
          else if (brd[ERR_BIT]) begin
            if (st_q == S_REPOLL) begin
              res_d = FSQ_RES_FAIL; st_d = S_RCV;
            end else st_d = S_REPOLL;
          end else if (brd[ABORT_BIT]) begin
            res_d = FSQ_RES_ABORT; st_d = S_RCV;
          end else if (st_q == S_POLL && brd[LOCK_HI_BIT] == wr_data[LOCK_HI_BIT]) st_d = S_FIN;
        end
      end
      S_RCV: begin
        bs = 1'b1; ba = base_q;
        // failure wants a plain reset; abort wants the matching abort-and-reset
        if (res_q == FSQ_RES_ABORT) begin
          bw = (op_q == FSQ_OP_EBP) ? CMD_EBP_ABRT : CMD_WBUF_ABRT;
        end else if (op_q == FSQ_OP_READ) begin
          bk = FSQ_BUS_RD;
        end else begin
          bw = CMD_RESET;
        end
        if (bdone) begin
          if (op_q == FSQ_OP_READ) rd_d = brd;
          st_d = S_FIN;
        end
      end
      S_LCHK: begin
        // indicator read inside extra-block mode only
        bs = 1'b1; bk = FSQ_BUS_RD; ba = XB_CUST_LO;
        if (bdone) begin
          rd_d = brd;
          if (brd[LOCK_HI_BIT] && brd[LOCK_ST_BIT]) begin
            res_d = FSQ_RES_LOCKD; st_d = S_EXIT;
          end else st_d = S_LPROG;
        end
      end
      S_LPROG: begin
        bs = 1'b1; ba = XB_CUST_LO; bw = CMD_XB_PROT & ~(16'h1 << PROT_BIT);
        if (bdone) st_d = S_EXIT;
      end
      S_EXIT: begin
        bs = 1'b1; ba = base_q; bw = CMD_XB_EXIT;
        if (bdone) st_d = S_FIN;
      end
      S_FIN: begin
        done_d = 1'b1; st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
    // program never aimed at the factory half of the extra block
    if (st_q == S_IDLE && op_valid && op == FSQ_OP_LOCK && op_addr < XB_CUST_LO) begin
      st_d = S_FIN; res_d = FSQ_RES_LOCKD;
    end
    busy_d = (st_d != S_IDLE);
  end

  always_ff @(posedge ref_clk or negedge rst_q_b) begin
    if (!rst_q_b) begin
      st_q <= S_IDLE; op_q <= FSQ_OP_WBUF; res_q <= FSQ_RES_OK;
      base_q <= 23'h0; cur_q <= 23'h0; left_q <= 9'h0; n_q <= 9'h0;
      wr_take <= 1'b0; op_busy <= 1'b0; op_done <= 1'b0;
      op_res <= FSQ_RES_OK; op_rdata <= 16'h0000;
    end else begin
      st_q <= st_d; op_q <= op_d; res_q <= res_d;
      base_q <= base_d; cur_q <= cur_d; left_q <= left_d; n_q <= n_d;
      wr_take <= take_d; op_busy <= busy_d; op_done <= done_d;
      op_res <= res_d; op_rdata <= rd_d;
    end
  end

  fsq_bus_cycle u_bus (
    .ref_clk(ref_clk), .rst_q_b(rst_q_b), .start(bs && !bdone), .kind(bk),
    .addr(ba), .wdata(bw), .done(bdone), .rdata(brd),
    .ce_b(ce_b), .we_b(we_b), .oe_b(oe_b), .adr(adr),
    .dq_o(dq_o), .dq_oe_b(dq_oe_b), .dq_i(dq_i)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  repoll_err_a: assert property (@(posedge ref_clk) disable iff (!rst_q_b)
    (st_q == S_POLL && bdone && brd[ERR_BIT] && brd[LOCK_HI_BIT] != wr_data[LOCK_HI_BIT])
      |=> st_q == S_REPOLL)
    else $error("error flag not re-polled");
  abort_rcv_a: assert property (@(posedge ref_clk) disable iff (!rst_q_b)
    (st_q == S_RCV && res_q == FSQ_RES_ABORT && bs)
      |-> bw == ((op_q == FSQ_OP_EBP) ? CMD_EBP_ABRT : CMD_WBUF_ABRT))
    else $error("wrong abort recovery command");
  lock_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_q_b)
    (st_q == S_LPROG && bdone) |=> st_q == S_EXIT)
    else $error("no exit after lock");
  locked_skip_a: assert property (@(posedge ref_clk) disable iff (!rst_q_b)
    (st_q == S_LCHK && bdone && brd[LOCK_HI_BIT] && brd[LOCK_ST_BIT]) |=> st_q != S_LPROG)
    else $error("locked section reprogrammed");
  ebp_base_a: assert property (@(posedge ref_clk) disable iff (!rst_q_b)
    (st_q == S_CMD && op_q == FSQ_OP_EBP) |-> base_q[7:0] == 8'h00)
    else $error("enhanced start not at 00");
  page_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_q_b)
    (st_q == S_DATA && op_q == FSQ_OP_WBUF) |-> same_page(cur_q, base_q))
    else $error("load outside buffer page");
endmodule
`default_nettype wire

// ### src/fsq_pkg.sv
// fsq_pkg: constants shared by the flash sequencer host controller
package fsq_pkg;
  // ---------------------------------------------------------------
  // status and indicator bit positions on the data bus
  // ---------------------------------------------------------------
  localparam int LOCK_HI_BIT   = 7; // lock_indicator_high_bit, also data-polling bit
  localparam int LOCK_ST_BIT   = 6; // lock_state_bit
  localparam int ERR_BIT       = 5; // error_flag_bit
  localparam int ABORT_BIT     = 1; // abort_flag_bit
  localparam int PROT_BIT      = 0; // extra_block_protection_bit
  // ---------------------------------------------------------------
  // extra block map
  // ---------------------------------------------------------------
  localparam logic [22:0] XB_CUST_LO = 23'h000080;
  localparam logic [22:0] XB_CUST_HI = 23'h0000FF;
  // ---------------------------------------------------------------
  // command codes (cycle encodings are defined by the device; neutral defaults)
  // ---------------------------------------------------------------
  localparam logic [15:0] CMD_RESET      = 16'h00F0;
  localparam logic [15:0] CMD_WBUF       = 16'h0025;
  localparam logic [15:0] CMD_WBUF_GO    = 16'h0029;
  localparam logic [15:0] CMD_WBUF_ABRT  = 16'h00F0;
  localparam logic [15:0] CMD_EBP        = 16'h0033;
  localparam logic [15:0] CMD_EBP_GO     = 16'h0029;
  localparam logic [15:0] CMD_EBP_ABRT   = 16'h0090;
  localparam logic [15:0] CMD_XB_PROT    = 16'h00A0;
  localparam logic [15:0] CMD_XB_EXIT    = 16'h0090;
  // ---------------------------------------------------------------
  // timing: bus strobe widths in ns at 100 MHz
  // ---------------------------------------------------------------
  localparam int CLK_NS     = 10;
  localparam int STROBE_NS  = 40;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // ---------------------------------------------------------------
  // user operations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FSQ_OP_WBUF = 2'h0,
    FSQ_OP_EBP  = 2'h1,
    FSQ_OP_LOCK = 2'h2,
    FSQ_OP_READ = 2'h3
  } fsq_op_t;
  // outcome reported to the user
  typedef enum logic [1:0] {
    FSQ_RES_OK    = 2'h0,
    FSQ_RES_FAIL  = 2'h1,
    FSQ_RES_ABORT = 2'h2,
    FSQ_RES_LOCKD = 2'h3
  } fsq_res_t;
  // bus cycle kind
  typedef enum logic [0:0] {
    FSQ_BUS_WR = 1'b0,
    FSQ_BUS_RD = 1'b1
  } fsq_bus_t;
endpackage

// ### src/fsq_bus_cycle.sv
// fsq_bus_cycle: one asynchronous chip-enable/write/output-enable bus cycle
`timescale 1ns/1ps
`default_nettype none
module fsq_bus_cycle
  import fsq_pkg::*;
#(
  parameter int STROBE = STROBE_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_q_b,
  input  wire logic        start,
  input  wire fsq_pkg::fsq_bus_t kind,
  input  wire logic [22:0] addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  output logic             ce_b,
  output logic             we_b,
  output logic             oe_b,
  output logic [22:0]      adr,
  output logic [15:0]      dq_o,
  output logic             dq_oe_b,
  input  wire logic [15:0] dq_i
);
  import fsq_pkg::*;

  logic [3:0]  cnt_q, cnt_d;
  logic        busy_q, busy_d, kind_q, kind_d, done_d;
  logic [15:0] rdata_d;

  always_comb begin
    busy_d  = busy_q;
    cnt_d   = cnt_q;
    kind_d  = kind_q;
    done_d  = 1'b0;
    rdata_d = rdata;
    if (!busy_q && start) begin
      busy_d = 1'b1;
      kind_d = kind;
      cnt_d  = 4'(STROBE);
    end else if (busy_q) begin
      if (cnt_q == 4'h1) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        if (kind_q == FSQ_BUS_RD) begin
          rdata_d = dq_i;
        end
      end
      cnt_d = cnt_q - 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_q_b) begin
    if (!rst_q_b) begin
      busy_q  <= 1'b0;
      cnt_q   <= 4'h0;
      kind_q  <= 1'b0;
      done    <= 1'b0;
      rdata   <= 16'h0000;
      ce_b    <= 1'b1;
      we_b    <= 1'b1;
      oe_b    <= 1'b1;
      adr     <= 23'h000000;
      dq_o    <= 16'h0000;
      dq_oe_b <= 1'b1;
    end else begin
      busy_q  <= busy_d;
      cnt_q   <= cnt_d;
      kind_q  <= kind_d;
      done    <= done_d;
      rdata   <= rdata_d;
      ce_b    <= ~busy_d;
      we_b    <= ~(busy_d && kind_d == FSQ_BUS_WR);
      oe_b    <= ~(busy_d && kind_d == FSQ_BUS_RD);
      dq_oe_b <= ~(busy_d && kind_d == FSQ_BUS_WR);
      if (!busy_q && start) begin
        adr  <= addr;
        dq_o <= wdata;
      end
    end
  end

  strobe_width_a: assert property (@(posedge ref_clk) disable iff (!rst_q_b)
    $fell(ce_b) |-> !ce_b [*4] ##1 ce_b)
    else $error("bus strobe width wrong");
endmodule
`default_nettype wire

// ### bench/fsq_flash_model.sv
// fsq_flash_model: behavioural flash device behind the host sequencer
`timescale 1ns/1ps
`default_nettype none
module fsq_flash_model
  import fsq_pkg::*;
(
  input  wire logic        ce_b,
  input  wire logic        we_b,
  input  wire logic        oe_b,
  input  wire logic [22:0] adr,
  input  wire logic [15:0] dq,
  input  wire logic [1:0]  mode,
  output logic [15:0]      dev_dq,
  output logic             stuck,
  output logic             locked,
  output logic             exited,
  output int               wcount
);
  // ---------------------------------------------------------------
  // states: 0 read, 1 loading, 2 polling, 3 failed, 4 aborted
  // ---------------------------------------------------------------
  logic [2:0]  st = 3'h0;
  logic        ebp = 1'b0;
  logic        wr_on, rd_on;
  logic [15:0] dq_l = 16'h0000;
  logic [22:0] adr_l = 23'h000000;
  logic [15:0] last_w = 16'h0000;
  logic [15:0] last_q = 16'h0000;
  logic [15:0] rd_val;
  logic        s7;
  int          polls = 0;
  initial locked = 1'b0;
  initial exited = 1'b0;
  initial wcount = 0;
  assign stuck = (st != 3'h0);
  assign wr_on = !ce_b && !we_b;
  assign rd_on = !ce_b && !oe_b;
  // polling bit shows the complement until a good program completes
  assign s7 = (st == 3'h2 && mode == 2'h0 && polls > 0) ? last_w[7] : ~last_w[7];
  assign rd_val = (st == 3'h0) ? {8'h00, 1'b1, locked, 5'h00, ~locked}
                : {8'h00, s7, 1'b0, mode == 2'h1, 3'h0, mode == 2'h2, 1'b0};
  // released bus shows the inverse of the last value, never a held copy
  assign dev_dq = (!ce_b && !oe_b) ? rd_val : ~last_q;
  // chip-enable and write-enable rise together and the host lets go of the
  // data bus in that same step, so the word is kept while both are low
  always @* begin
    if (!ce_b && !we_b) begin
      dq_l = dq;
      adr_l = adr;
    end
  end
  always @(negedge wr_on) begin
    case (st)
      3'h1: begin
        if (dq_l == CMD_WBUF_GO) begin
          st <= 3'h2;
          polls <= 0;
        end else begin
          wcount <= wcount + 1;
          last_w <= dq_l;
        end
      end
      3'h3: if (dq_l == CMD_RESET) st <= 3'h0;
      3'h4: if (dq_l == (ebp ? CMD_EBP_ABRT : CMD_WBUF_ABRT)) st <= 3'h0;
      3'h2: ;
      default: begin
        if (dq_l == CMD_WBUF || dq_l == CMD_EBP) begin
          st <= 3'h1;
          ebp <= (dq_l == CMD_EBP);
          wcount <= 0;
        end else if (adr_l >= XB_CUST_LO && adr_l <= XB_CUST_HI
                     && dq_l == (CMD_XB_PROT & ~(16'h1 << PROT_BIT))) begin
          // never cleared: the lock is one way
          locked <= 1'b1;
        end
        if (dq_l == CMD_XB_EXIT) exited <= 1'b1;
      end
    endcase
  end
  always @(negedge rd_on) begin
    last_q <= rd_val;
    if (st == 3'h2) begin
      polls <= polls + 1;
      if (mode == 2'h1) st <= 3'h3;
      if (mode == 2'h2) st <= 3'h4;
      if (mode == 2'h0 && polls > 0) st <= 3'h0;
    end
  end
endmodule
`default_nettype wire

// ### bench/flash_otp_lock_and_buffer_program_tb.sv
// flash_otp_lock_and_buffer_program_tb: self-checking bench for the host sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_otp_lock_and_buffer_program_tb;
  import fsq_pkg::*;
  typedef struct {fsq_op_t op; logic [22:0] a; logic [8:0] n; logic [1:0] m;
                  fsq_res_t r; logic lk; logic [15:0] d;} fsq_row_t;
  logic ref_clk = 1'b0, rst_b = 1'b0, op_valid = 1'b0, wr_take, op_busy, op_done;
  logic ce_b, we_b, oe_b, dq_oe_b, stuck, locked, exited;
  fsq_op_t op = FSQ_OP_READ;
  fsq_res_t op_res;
  logic [22:0] op_addr = 23'h000000, adr;
  logic [8:0] op_count = 9'h000;
  logic [7:0] wdn = 8'h00;
  logic [15:0] op_rdata, dq_o, dq_i, dev_dq;
  logic [1:0] mode = 2'h0;
  int fails = 0, compares = 0, wcount, k, pulses;
  fsq_row_t rows[13];
  always #5 ref_clk = ~ref_clk;
  assign dq_i = !dq_oe_b ? dq_o : dev_dq;
  always @(negedge ref_clk) wdn <= op_valid ? 8'h00 : wdn + {7'h00, wr_take === 1'b1};
  // the poll compares against bit 7 of wr_data, which already shows the word
  // after the last one loaded, so bit 7 is held at 0 in every word
  fsq_ctrl dut (.ref_clk(ref_clk), .rst_b(rst_b), .op_valid(op_valid), .op(op),
    .op_addr(op_addr), .op_count(op_count), .wr_data({8'hA5, 1'b0, wdn[6:0]}),
    .wr_take(wr_take),
    .op_busy(op_busy), .op_done(op_done), .op_res(op_res), .op_rdata(op_rdata),
    .ce_b(ce_b), .we_b(we_b), .oe_b(oe_b), .adr(adr), .dq_o(dq_o), .dq_oe_b(dq_oe_b),
    .dq_i(dq_i));
  fsq_flash_model dev (.ce_b(ce_b), .we_b(we_b), .oe_b(oe_b), .adr(adr), .dq(dq_i),
    .mode(mode), .dev_dq(dev_dq), .stuck(stuck), .locked(locked), .exited(exited),
    .wcount(wcount));
  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one operation; a refused request while busy is offered when poke is set
  task automatic run_op(input fsq_row_t r, input logic poke);
    @(negedge ref_clk);
    op = r.op;
    op_addr = r.a;
    op_count = r.n;
    mode = r.m;
    op_valid = 1'b1;
    @(negedge ref_clk);
    op_valid = 1'b0;
    pulses = 0;
    for (int i = 0; i < 20000 && pulses == 0; i++) begin
      if (poke && i == 3) begin
        op = FSQ_OP_LOCK;
        op_valid = 1'b1;
      end
      if (i == 8) op_valid = 1'b0;
      @(negedge ref_clk);
      pulses += (op_done === 1'b1);
    end
    check(pulses, 1);
    check(op_res, r.r);
    check(op_rdata, r.d);
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    test_done();
  end
  initial begin
    rows = '{'{FSQ_OP_LOCK, 23'h000010, 9'h000, 2'h0, FSQ_RES_LOCKD, 1'b0, 16'h0000},
             '{FSQ_OP_LOCK, 23'h000080, 9'h000, 2'h0, FSQ_RES_OK, 1'b1, 16'h0081},
             '{FSQ_OP_LOCK, 23'h0000FF, 9'h000, 2'h0, FSQ_RES_LOCKD, 1'b1, 16'h00C0},
             '{FSQ_OP_WBUF, 23'h001000, 9'h003, 2'h0, FSQ_RES_OK, 1'b1, 16'h00C0},
             '{FSQ_OP_WBUF, 23'h001234, 9'h003, 2'h1, FSQ_RES_FAIL, 1'b1, 16'h00C0},
             '{FSQ_OP_WBUF, 23'h001000, 9'h003, 2'h2, FSQ_RES_ABORT, 1'b1, 16'h00C0},
             '{FSQ_OP_WBUF, 23'h001000, 9'h01F, 2'h0, FSQ_RES_OK, 1'b1, 16'h00C0},
             '{FSQ_OP_WBUF, 23'h002000, 9'h000, 2'h0, FSQ_RES_OK, 1'b1, 16'h00C0},
             '{FSQ_OP_EBP, 23'h004000, 9'h000, 2'h0, FSQ_RES_OK, 1'b1, 16'h00C0},
             '{FSQ_OP_EBP, 23'h004000, 9'h000, 2'h1, FSQ_RES_FAIL, 1'b1, 16'h00C0},
             '{FSQ_OP_EBP, 23'h004000, 9'h000, 2'h2, FSQ_RES_ABORT, 1'b1, 16'h00C0},
             '{FSQ_OP_READ, 23'h000080, 9'h000, 2'h0, FSQ_RES_OK, 1'b1, 16'h00C0},
             '{FSQ_OP_WBUF, 23'h001010, 9'h01F, 2'h0, FSQ_RES_OK, 1'b1, 16'h00C0}};
    repeat (5) @(posedge ref_clk);
    check({ce_b, we_b, oe_b, dq_oe_b, op_busy, op_done}, 32'h3C);
    @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (3) @(posedge ref_clk);
    // ---------------------------------------------------------------
    // table of ordinary operations
    // ---------------------------------------------------------------
    for (k = 0; k < 12; k++) begin
      run_op(rows[k], 1'b0);
      check(stuck, 1'b0);
      check(locked, rows[k].lk);
      if (rows[k].op == FSQ_OP_WBUF && rows[k].r == FSQ_RES_OK)
        check(wcount, rows[k].n + 2);
      if (rows[k].op == FSQ_OP_LOCK && rows[k].r == FSQ_RES_OK)
        check(exited, 1'b1);
    end
    // ---------------------------------------------------------------
    // request offered while busy must be ignored
    // ---------------------------------------------------------------
    run_op(rows[3], 1'b1);
    check(wcount, 5);
    // a load that starts half way into a page stops at the page edge
    run_op(rows[12], 1'b0);
    check(wcount, 17);
    // ---------------------------------------------------------------
    // reset pulled in the middle of a bus cycle
    // ---------------------------------------------------------------
    @(negedge ref_clk);
    op = FSQ_OP_READ;
    op_valid = 1'b1;
    @(negedge ref_clk);
    op_valid = 1'b0;
    repeat (3) @(negedge ref_clk);
    check(ce_b, 1'b0);
    rst_b = 1'b0;
    @(negedge ref_clk);
    check({ce_b, we_b, oe_b, dq_oe_b, op_busy, op_done}, 32'h3C);
    check(op_rdata, 16'h0000);
    rst_b = 1'b1;
    repeat (3) @(posedge ref_clk);
    run_op(rows[11], 1'b0);
    check(stuck, 1'b0);
    repeat (20) @(posedge ref_clk);
    #1 check(op_busy, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
